// [include/dio_pkg.sv]
// constants, register map and command codes for the 4-bit digital port block
// Functional notes
// - input mode: tests, loads, arithmetic and compares read the pin levels
// - input mode: 4-bit store writes output latch only, buffer stays off
// - input mode: exchange returns pins, latches accumulator, buffer stays off
// - input mode: increment-and-skip latches pin value plus one, buffer stays off
// - input mode: bit writes update addressed latch bit; other bits may change
// - output mode: tests, loads, arithmetic and compares read the output latch
// - output mode: 4-bit store updates latch and drives pins together
// - output mode: exchange swaps latch with accumulator, pins show new latch
// - output mode: increment-and-skip adds one to latch and drives it out
// - output mode: bit writes change only the addressed bit and its pin
// - pull-ups of ports 3, 6, 8 act only in input mode
// - port 3 and 6 pull-ups follow group A bits 3 and 6, whole port
// - port 8 pull-up follows group B bit 0
// - port 7 pull-ups are fixed per pin at build time
// - pull-up enable bit 0 disconnects, 1 connects
package dio_pkg;

  localparam int DIO_NPORT = 4;
  localparam int DIO_PW    = 4;

  // register byte offsets
  localparam logic [11:0] DIO_OFF_DATA3 = 12'h000;
  localparam logic [11:0] DIO_OFF_DATA6 = 12'h004;
  localparam logic [11:0] DIO_OFF_DATA7 = 12'h008;
  localparam logic [11:0] DIO_OFF_DATA8 = 12'h00c;
  localparam logic [11:0] DIO_OFF_DIR   = 12'h010;
  localparam logic [11:0] DIO_OFF_PUA   = 12'h014;
  localparam logic [11:0] DIO_OFF_PUB   = 12'h018;
  localparam logic [11:0] DIO_OFF_CMD   = 12'h01c;

  // command register fields
  localparam int DIO_CMD_ACC_LSB  = 0;
  localparam int DIO_CMD_BIT_LSB  = 4;
  localparam int DIO_CMD_PORT_LSB = 6;
  localparam int DIO_CMD_OP_LSB   = 8;
  localparam int DIO_CMD_CY_BIT   = 12;
  localparam int DIO_RES_SKIP_BIT = 4;

  // pull-up enable bit positions
  localparam int DIO_PUA_P3_BIT = 3;
  localparam int DIO_PUA_P6_BIT = 6;
  localparam int DIO_PUB_P8_BIT = 0;

  // reset values
  localparam logic [3:0] DIO_DIR_RST   = 4'h0;
  localparam logic [7:0] DIO_PUA_RST   = 8'h00;
  localparam logic [7:0] DIO_PUB_RST   = 8'h00;
  localparam logic [3:0] DIO_LATCH_RST = 4'h0;
  localparam logic [4:0] DIO_RES_RST   = 5'h00;

  localparam logic [1:0] DIO_RESP_OKAY   = 2'h0;
  localparam logic [1:0] DIO_RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    DIO_OP_NONE,
    DIO_OP_XCH,
    DIO_OP_INCREMENT_AND_SKIP,
    DIO_OP_SET,
    DIO_OP_CLR,
    DIO_OP_MOVC,
    DIO_OP_TCLR,
    DIO_OP_WR4
  } dio_op_t;

endpackage

// [core/dio_port_slice.sv]
// one 4-bit port: output latch, read source and instruction effects
`timescale 1ns/1ps
module dio_port_slice #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // mode and pins
  input  wire logic             out_mode,
  input  wire logic [W-1:0]     pin_in,
  // command
  input  wire logic             cmd_v,
  input  wire dio_pkg::dio_op_t cmd_op,
  input  wire logic [1:0]       cmd_bit,
  input  wire logic [W-1:0]     cmd_acc,
  input  wire logic             cmd_cy,
  // state and results
  output logic      [W-1:0]     latch_q,
  output logic      [W-1:0]     operand,
  output logic      [W-1:0]     result,
  output logic                  skip
);
  import dio_pkg::*;

  logic [W-1:0] latch_d;
  logic [W-1:0] incd;
  logic [W-1:0] onehot;

  // pins in input mode, latch in output mode
  assign operand = out_mode ? latch_q : pin_in;
  assign incd    = operand + W'(1);
  assign onehot  = W'(1) << cmd_bit;
  assign result  = operand;

  // bit ops start from the operand: in input mode the other bits
  // pick up the pin levels, which is the documented undefined case
  always_comb begin
    latch_d = latch_q;
    skip    = 1'b0;
    if (cmd_v) begin
      case (cmd_op)
        DIO_OP_WR4:  latch_d = cmd_acc;
        DIO_OP_XCH:  latch_d = cmd_acc;
        DIO_OP_INCREMENT_AND_SKIP: begin
          latch_d = incd;
          skip    = (incd == '0);
        end
        DIO_OP_SET:  latch_d = operand | onehot;
        DIO_OP_CLR:  latch_d = operand & ~onehot;
        DIO_OP_MOVC: latch_d = cmd_cy ? (operand | onehot) : (operand & ~onehot);
        DIO_OP_TCLR: begin
          skip    = operand[cmd_bit];
          latch_d = operand & ~onehot;
        end
        default:     latch_d = latch_q;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latch_q <= W'(DIO_LATCH_RST);
    end else begin
      latch_q <= latch_d;
    end
  end

endmodule

// [core/dio_gpio.sv]
// four 4-bit digital ports with pull-up control behind an AXI4-Lite slave
`timescale 1ns/1ps
module dio_gpio #(
  parameter int         AW           = 12,
  parameter logic [3:0] PORT7_PULLUP = 4'h0
) (
  // clock and reset
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // write address
  input  wire logic [AW-1:0] awaddr,
  input  wire logic          awvalid,
  output logic               awready,
  // write data
  input  wire logic [31:0]   wdata,
  input  wire logic [3:0]    wstrb,
  input  wire logic          wvalid,
  output logic               wready,
  // write response
  output logic [1:0]         bresp,
  output logic               bvalid,
  input  wire logic          bready,
  // read address
  input  wire logic [AW-1:0] araddr,
  input  wire logic          arvalid,
  output logic               arready,
  // read data
  output logic [31:0]        rdata,
  output logic [1:0]         rresp,
  output logic               rvalid,
  input  wire logic          rready,
  // port pins, ports 3, 6, 7, 8 from low to high
  input  wire logic [15:0]   pin_in,
  output logic [15:0]        pin_out,
  output logic [15:0]        pin_oe,
  output logic [15:0]        pullup_on
);
  import dio_pkg::*;

  localparam int NP = DIO_NPORT;
  localparam int PW = DIO_PW;

  // {hit, index}: 0-3 data, 4 dir, 5 group a, 6 group b, 7 cmd
  function automatic logic [3:0] reg_index(input logic [AW-1:0] a);
    logic [3:0] r;
    r = 4'h0;
    case (a)
      AW'(DIO_OFF_DATA3): r = 4'h8;
      AW'(DIO_OFF_DATA6): r = 4'h9;
      AW'(DIO_OFF_DATA7): r = 4'ha;
      AW'(DIO_OFF_DATA8): r = 4'hb;
      AW'(DIO_OFF_DIR):   r = 4'hc;
      AW'(DIO_OFF_PUA):   r = 4'hd;
      AW'(DIO_OFF_PUB):   r = 4'he;
      AW'(DIO_OFF_CMD):   r = 4'hf;
      default:            r = 4'h0;
    endcase
    return r;
  endfunction

  // write channel state
  logic          aw_held_q;
  logic          aw_held_d;
  logic [AW-1:0] awaddr_q;
  logic          w_held_q;
  logic          w_held_d;
  logic [31:0]   wdata_q;
  logic          wstrb0_q;
  logic          awready_q;
  logic          wready_q;
  logic          bvalid_q;
  logic          bvalid_d;
  logic [1:0]    bresp_q;
  // read channel state
  logic          arready_q;
  logic          rvalid_q;
  logic          rvalid_d;
  logic [31:0]   rdata_q;
  logic [1:0]    rresp_q;
  // control registers
  logic [3:0]    dir_q;
  logic [3:0]    dir_d;
  logic [15:0]   oe_d;
  logic [15:0]   oe_q;
  logic [7:0]    pua_q;
  logic [7:0]    pua_d;
  logic [7:0]    pub_q;
  logic [7:0]    pub_d;
  logic [4:0]    result_q;
  logic [4:0]    result_d;
  logic [15:0]   pu_d;
  logic [15:0]   pu_q;

  wire aw_hs = awvalid && awready_q;
  wire w_hs  = wvalid && wready_q;
  wire ar_hs = arvalid && arready_q;
  wire do_wr = aw_held_q && w_held_q && !bvalid_q;

  wire [3:0] wr_sel = reg_index(awaddr_q);
  wire       wr_hit = wr_sel[3];
  wire [2:0] wr_idx = wr_sel[2:0];
  // a write without byte lane 0 is acknowledged and ignored
  wire       wr_ok  = do_wr && wr_hit && wstrb0_q;
  wire [3:0] rd_sel = reg_index(araddr);

  // port commands: data register writes are 4-bit stores
  wire              wr_cmd   = (wr_idx == 3'd7);
  wire              cmd_v    = wr_ok && (!wr_idx[2] || wr_cmd);
  wire [1:0]        cmd_port = wr_cmd ? wdata_q[DIO_CMD_PORT_LSB +: 2] : wr_idx[1:0];
  wire dio_op_t     cmd_op   = wr_cmd ? dio_op_t'(wdata_q[DIO_CMD_OP_LSB +: 3]) : DIO_OP_WR4;
  wire [1:0]        cmd_bit  = wdata_q[DIO_CMD_BIT_LSB +: 2];
  wire [PW-1:0]     cmd_acc  = wdata_q[DIO_CMD_ACC_LSB +: PW];
  wire              cmd_cy   = wdata_q[DIO_CMD_CY_BIT];

  logic [PW-1:0] lat  [NP];
  logic [PW-1:0] opnd [NP];
  logic [PW-1:0] res  [NP];
  logic          skp  [NP];

  genvar i;
  generate
    for (i = 0; i < NP; i++) begin : g_port
      dio_port_slice #(
        .W (PW)
      ) u_slice (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .out_mode (dir_q[i]),
        .pin_in   (pin_in[i*PW +: PW]),
        .cmd_v    (cmd_v && (cmd_port == 2'(i))),
        .cmd_op   (cmd_op),
        .cmd_bit  (cmd_bit),
        .cmd_acc  (cmd_acc),
        .cmd_cy   (cmd_cy),
        .latch_q  (lat[i]),
        .operand  (opnd[i]),
        .result   (res[i]),
        .skip     (skp[i])
      );
      assign pin_out[i*PW +: PW] = lat[i];
      assign oe_d[i*PW +: PW]    = {PW{dir_d[i]}};
    end
  endgenerate

  // channel bookkeeping; the next ready is derived so it is a plain flop
  assign aw_held_d = aw_hs ? 1'b1 : (do_wr ? 1'b0 : aw_held_q);
  assign w_held_d  = w_hs ? 1'b1 : (do_wr ? 1'b0 : w_held_q);
  assign bvalid_d  = do_wr ? 1'b1 : (bready ? 1'b0 : bvalid_q);
  assign rvalid_d  = ar_hs ? 1'b1 : (rready ? 1'b0 : rvalid_q);

  assign dir_d    = (wr_ok && wr_idx == 3'd4) ? wdata_q[3:0] : dir_q;
  assign pua_d    = (wr_ok && wr_idx == 3'd5) ? wdata_q[7:0] : pua_q;
  assign pub_d    = (wr_ok && wr_idx == 3'd6) ? wdata_q[7:0] : pub_q;
  assign result_d = cmd_v ? {skp[cmd_port], res[cmd_port]} : result_q;

  // pull-ups of ports 3, 6, 8 drop in output mode, a cycle after the buffer turns on; port 7 stays at PORT7_PULLUP
  assign pu_d[3:0]   = {PW{!dir_q[0] && pua_q[DIO_PUA_P3_BIT]}};
  assign pu_d[7:4]   = {PW{!dir_q[1] && pua_q[DIO_PUA_P6_BIT]}};
  assign pu_d[11:8]  = PORT7_PULLUP;
  assign pu_d[15:12] = {PW{!dir_q[3] && pub_q[DIO_PUB_P8_BIT]}};

  // read data: the port operand is what a load instruction would see
  logic [31:0] rd_data;
  always_comb begin
    rd_data = 32'h0;
    case (rd_sel[2:0])
      3'd4:    rd_data = {28'h0, dir_q};
      3'd5:    rd_data = {24'h0, pua_q};
      3'd6:    rd_data = {24'h0, pub_q};
      3'd7:    rd_data = {27'h0, result_q};
      default: rd_data = {28'h0, opnd[rd_sel[1:0]]};
    endcase
    if (!rd_sel[3]) begin
      rd_data = 32'h0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= 32'h0;
      wstrb0_q  <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= DIO_RESP_OKAY;
    end else begin
      aw_held_q <= aw_held_d;
      w_held_q  <= w_held_d;
      awready_q <= !aw_held_d && !bvalid_d;
      wready_q  <= !w_held_d && !bvalid_d;
      bvalid_q  <= bvalid_d;
      if (aw_hs) begin
        awaddr_q <= awaddr;
      end
      if (w_hs) begin
        wdata_q  <= wdata;
        wstrb0_q <= wstrb[0];
      end
      if (do_wr) begin
        bresp_q <= wr_hit ? DIO_RESP_OKAY : DIO_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0;
      rresp_q   <= DIO_RESP_OKAY;
    end else begin
      arready_q <= !rvalid_d;
      rvalid_q  <= rvalid_d;
      if (ar_hs) begin
        rdata_q <= rd_data;
        rresp_q <= rd_sel[3] ? DIO_RESP_OKAY : DIO_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir_q    <= DIO_DIR_RST;
      oe_q     <= '0;
      pua_q    <= DIO_PUA_RST;
      pub_q    <= DIO_PUB_RST;
      result_q <= DIO_RES_RST;
      pu_q     <= '0;
    end else begin
      dir_q    <= dir_d;
      oe_q     <= oe_d;
      pua_q    <= pua_d;
      pub_q    <= pub_d;
      result_q <= result_d;
      pu_q     <= pu_d;
    end
  end

  assign awready   = awready_q;
  assign wready    = wready_q;
  assign bvalid    = bvalid_q;
  assign bresp     = bresp_q;
  assign arready   = arready_q;
  assign rvalid    = rvalid_q;
  assign rdata     = rdata_q;
  assign rresp     = rresp_q;
  assign pin_oe    = oe_q;
  assign pullup_on = pu_q;

  // checks, on port 3 where a port is needed, except the all-port direction check and the port 7 and port 8 pull-up checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_cmd3(dio_op_t op);
    cmd_v && cmd_port == 2'd0 && cmd_op == op;
  endsequence

  sequence s_wr_both;
    aw_hs && w_hs && !aw_held_q && !w_held_q && !bvalid_q;
  endsequence

  a_in_store_quiet: assert property (
    s_cmd3(DIO_OP_WR4) ##0 !dir_q[0] |=> lat[0] == $past(cmd_acc) && pin_oe[3:0] == 4'h0)
    else $error("input-mode store wrong or buffer on");

  a_out_store_drive: assert property (
    s_cmd3(DIO_OP_WR4) ##0 dir_q[0] |=> pin_out[3:0] == $past(cmd_acc) && pin_oe[3:0] == 4'hf)
    else $error("output-mode store not driven");

  a_exchange_swap: assert property (
    s_cmd3(DIO_OP_XCH) |=> lat[0] == $past(cmd_acc) && result_q[3:0] == $past(opnd[0]))
    else $error("exchange result wrong");

  a_increment_and_skip_plus_one: assert property (
    s_cmd3(DIO_OP_INCREMENT_AND_SKIP) |=> lat[0] == 4'($past(opnd[0]) + 4'h1))
    else $error("increment result wrong");

  a_in_bit_set: assert property (
    s_cmd3(DIO_OP_SET) ##0 !dir_q[0] |=> lat[0][$past(cmd_bit)])
    else $error("addressed bit not set");

  a_out_bit_only: assert property (
    s_cmd3(DIO_OP_CLR) ##0 dir_q[0] |=> lat[0] == ($past(lat[0]) & ~(4'h1 << $past(cmd_bit))))
    else $error("output bit clear touched other bits");

  a_read_source: assert property (
    ar_hs && araddr == AW'(DIO_OFF_DATA3)
      |=> rvalid_q && rdata_q[3:0] == ($past(dir_q[0]) ? $past(lat[0]) : $past(pin_in[3:0])))
    else $error("port read from wrong source");

  a_pullup_p3_mode: assert property (
    $stable(dir_q[0]) && $stable(pua_q[3])
      |=> pullup_on[3:0] == {4{!$past(dir_q[0]) && $past(pua_q[3])}})
    else $error("port 3 pull-up wrong");

  a_pullup_p8_mode: assert property (
    dir_q[3] |=> pullup_on[15:12] == 4'h0)
    else $error("port 8 pull-up on in output mode");

  a_pullup_p7_fixed: assert property (
    $rose(aresetn) |=> pullup_on[11:8] == PORT7_PULLUP [*2])
    else $error("port 7 pull-up not fixed");

  a_dir_to_buffer: assert property (
    wr_ok && wr_idx == 3'd4
      |=> pin_oe == {{4{$past(wdata_q[3])}}, {4{$past(wdata_q[2])}}, {4{$past(wdata_q[1])}}, {4{$past(wdata_q[0])}}})
    else $error("direction not applied to buffers");

  a_write_answer: assert property (
    s_wr_both |-> ##2 bvalid_q)
    else $error("write response late");

endmodule

// [testbench/dio_pin_model.sv]
// external circuitry on the sixteen port pins
`timescale 1ns/1ps
module dio_pin_model (
  // clock
  input  wire logic        aclk,
  // device side
  input  wire logic [15:0] pin_out,
  input  wire logic [15:0] pin_oe,
  input  wire logic [15:0] pullup_on,
  // bench side
  input  wire logic [15:0] ext_val,
  input  wire logic [15:0] ext_en,
  output logic      [15:0] pin_in
);
  logic [15:0] float_q = 16'h0000;

  // a floating pin must never look like a stable value
  always_ff @(posedge aclk) begin
    float_q <= ~float_q;
  end

  // device buffer wins, then outside driver, then pull-up
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] : pullup_on[i] ? 1'b1 : float_q[i];
    end
  end
endmodule

// [testbench/digital_io_port_latch_pullup_test.sv]
// self-checking bench for the 4-bit digital port block
`timescale 1ns/1ps
module digital_io_port_latch_pullup_test;
  import dio_pkg::*;
  localparam logic [3:0] P7PU = 4'ha;
  logic        aclk     = 1'b0;
  logic        aresetn  = 1'b0;
  logic [11:0] awaddr   = 12'h000;
  logic [11:0] araddr   = 12'h000;
  logic        awvalid  = 1'b0;
  logic        wvalid   = 1'b0;
  logic        arvalid  = 1'b0;
  logic        bready   = 1'b1;
  logic        rready   = 1'b1;
  logic [31:0] wdata    = 32'h0;
  logic [3:0]  wstrb    = 4'h0;
  logic [15:0] ext_val  = 16'h0000;
  logic [15:0] ext_en   = 16'hffff;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, rsp;
  logic [31:0] rdata, rd;
  logic [15:0] pin_in, pin_out, pin_oe, pullup_on;
  int          n_fail = 0;
  int          samples_checked = 0;

  always #4 aclk = ~aclk;

  dio_gpio #(.AW(12), .PORT7_PULLUP(P7PU)) uut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pullup_on(pullup_on));

  dio_pin_model pm (.aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_on(pullup_on),
    .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // bready stays high, so the answer is taken at the edge it is seen
  task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    bit ad;
    bit wd;
    ad = 0;
    wd = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        wd = 1;
        wvalid <= 1'b0;
      end
    end
    do begin
      @(posedge aclk);
    end while (!bvalid);
    rsp = bresp;
    #1;
  endtask

  // no cycle count is assumed: only the watchdog ends a wait
  task automatic axr(input logic [11:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
    end while (!arready);
    arvalid <= 1'b0;
    do begin
      @(posedge aclk);
    end while (!rvalid);
    rd = rdata;
    rsp = rresp;
    #1;
  endtask

  function automatic logic [31:0] cw(input logic [3:0] acc, input logic [1:0] b, input logic [1:0] p,
                                     input dio_op_t op, input logic cy);
    cw = {19'h0, cy, 1'b0, op, p, b, acc};
  endfunction

  task automatic settle;
    @(posedge aclk);
    #1;
  endtask

  task automatic t_reset;
    chk("pin_oe", 32'h0, pin_oe);
    chk("pin_out", 32'h0, pin_out);
    chk("pullup_on", {20'h0, P7PU, 8'h00}, pullup_on);
    axr(DIO_OFF_DIR);
    chk("dir", 32'h0, rd);
    axr(DIO_OFF_PUA);
    chk("pua", 32'h0, rd);
    axr(DIO_OFF_PUB);
    chk("pub", 32'h0, rd);
    $display("test reset done");
  endtask

  task automatic t_input;
    @(posedge aclk);
    ext_val <= 16'hc005;
    axr(DIO_OFF_DATA3);
    chk("p3 pins", 32'h5, rd);
    axr(DIO_OFF_DATA8);
    chk("p8 pins", 32'hc, rd);
    axw(DIO_OFF_DATA3, 32'ha, 4'h1);
    chk("p3 latch", 32'ha, pin_out[3:0]);
    chk("p3 oe", 32'h0, pin_oe);
    axr(DIO_OFF_DATA3);
    chk("p3 pins again", 32'h5, rd);
    axw(DIO_OFF_CMD, cw(4'h3, 2'h0, 2'h0, DIO_OP_XCH, 1'b0), 4'h1);
    chk("xch latch", 32'h3, pin_out[3:0]);
    axr(DIO_OFF_CMD);
    chk("xch acc", 32'h5, rd[3:0]);
    @(posedge aclk);
    ext_val <= 16'hc00f;
    axw(DIO_OFF_CMD, cw(4'h0, 2'h0, 2'h0, DIO_OP_INCREMENT_AND_SKIP, 1'b0), 4'h1);
    chk("increment_and_skip latch", 32'h0, pin_out[3:0]);
    chk("increment_and_skip oe", 32'h0, pin_oe);
    axr(DIO_OFF_CMD);
    chk("increment_and_skip skip", 32'h1f, rd[4:0]);
    @(posedge aclk);
    ext_val <= 16'h0000;
    axw(DIO_OFF_CMD, cw(4'h0, 2'h2, 2'h0, DIO_OP_SET, 1'b0), 4'h1);
    chk("set bit", 32'h1, pin_out[2]);
    axw(DIO_OFF_CMD, cw(4'h0, 2'h1, 2'h3, DIO_OP_SET, 1'b0), 4'h1);
    chk("p8 set bit", 32'h1, pin_out[13]);
    axw(DIO_OFF_CMD, cw(4'h7, 2'h0, 2'h1, DIO_OP_WR4, 1'b0), 4'h1);
    chk("p6 cmd store", 32'h7, pin_out[7:4]);
    chk("p6 cmd oe", 32'h0, pin_oe);
    axw(DIO_OFF_CMD, cw(4'h2, 2'h0, 2'h1, DIO_OP_NONE, 1'b0), 4'h1);
    chk("p6 no-op", 32'h7, pin_out[7:4]);
    $display("test input mode done");
  endtask

  task automatic t_output;
    axw(DIO_OFF_DIR, 32'h9, 4'h1);
    chk("oe", 32'hf00f, pin_oe);
    axw(DIO_OFF_DATA3, 32'h9, 4'h1);
    chk("store pins", 32'h9, pin_out[3:0]);
    axr(DIO_OFF_DATA3);
    chk("latch read", 32'h9, rd);
    axw(DIO_OFF_CMD, cw(4'hc, 2'h0, 2'h0, DIO_OP_XCH, 1'b0), 4'h1);
    chk("xch pins", 32'hc, pin_out[3:0]);
    axr(DIO_OFF_CMD);
    chk("xch acc", 32'h9, rd[3:0]);
    axw(DIO_OFF_CMD, cw(4'h0, 2'h0, 2'h0, DIO_OP_INCREMENT_AND_SKIP, 1'b0), 4'h1);
    chk("increment_and_skip pins", 32'hd, pin_out[3:0]);
    axr(DIO_OFF_CMD);
    chk("increment_and_skip noskip", 32'h0c, rd[4:0]);
    axw(DIO_OFF_CMD, cw(4'h0, 2'h2, 2'h0, DIO_OP_CLR, 1'b0), 4'h1);
    chk("p3 clr", 32'h9, pin_out[3:0]);
    axw(DIO_OFF_DATA8, 32'hf, 4'h1);
    axw(DIO_OFF_CMD, cw(4'h0, 2'h1, 2'h3, DIO_OP_CLR, 1'b0), 4'h1);
    chk("clr", 32'hd, pin_out[15:12]);
    axw(DIO_OFF_CMD, cw(4'h0, 2'h0, 2'h3, DIO_OP_MOVC, 1'b0), 4'h1);
    chk("movc 0", 32'hc, pin_out[15:12]);
    axw(DIO_OFF_CMD, cw(4'h0, 2'h1, 2'h3, DIO_OP_MOVC, 1'b1), 4'h1);
    chk("movc 1", 32'he, pin_out[15:12]);
    axw(DIO_OFF_CMD, cw(4'h0, 2'h3, 2'h3, DIO_OP_TCLR, 1'b0), 4'h1);
    chk("tclr", 32'h6, pin_out[15:12]);
    axr(DIO_OFF_CMD);
    chk("tclr skip", 32'h1, rd[4]);
    $display("test output mode done");
  endtask

  task automatic t_errors;
    axw(12'h020, 32'h1, 4'h1);
    chk("unmapped wr", DIO_RESP_SLVERR, rsp);
    axw(12'h002, 32'h1, 4'h1);
    chk("misaligned wr", DIO_RESP_SLVERR, rsp);
    axr(12'h024);
    chk("unmapped rd", DIO_RESP_SLVERR, rsp);
    chk("unmapped data", 32'h0, rd);
    axw(DIO_OFF_DATA3, 32'h5, 4'h0);
    chk("no strobe resp", DIO_RESP_OKAY, rsp);
    axr(DIO_OFF_DATA3);
    chk("no strobe latch", 32'h9, rd);
    $display("test errors done");
  endtask

  task automatic t_pullup;
    axw(DIO_OFF_DIR, 32'h0, 4'h1);
    axw(DIO_OFF_PUA, 32'hb7, 4'h1);
    axw(DIO_OFF_PUB, 32'hfe, 4'h1);
    settle;
    chk("other bits", {20'h0, P7PU, 8'h00}, pullup_on);
    axr(DIO_OFF_PUA);
    chk("pua rw", 32'hb7, rd);
    axr(DIO_OFF_PUB);
    chk("pub rw", 32'hfe, rd);
    axw(DIO_OFF_PUA, 32'h48, 4'h1);
    axw(DIO_OFF_PUB, 32'h01, 4'h1);
    settle;
    chk("all on", {16'h0, 4'hf, P7PU, 8'hff}, pullup_on);
    axw(DIO_OFF_PUA, 32'h08, 4'h1);
    settle;
    chk("p6 off", {16'h0, 4'hf, P7PU, 8'h0f}, pullup_on);
    // release port 3 so only its pull-up holds the pins
    @(posedge aclk);
    ext_en <= 16'hfff0;
    axr(DIO_OFF_DATA3);
    chk("p3 pulled", 32'hf, rd);
    @(posedge aclk);
    ext_en <= 16'hffff;
    axw(DIO_OFF_DIR, 32'hf, 4'h1);
    settle;
    chk("output off", {20'h0, P7PU, 8'h00}, pullup_on);
    $display("test pull-ups done");
  endtask

  task automatic stop_test;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    #100000;
    n_fail++;
    stop_test;
  end

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    settle;
    t_reset;
    t_input;
    t_output;
    t_errors;
    t_pullup;
    stop_test;
  end
endmodule
